// ### pkg/mcc_map.vh
/*
 * Register indices, bit positions, reset values and conversion counts
 * for the monitor configuration block.
 * Assumes it is included by bare name; definitions only.
 */
`ifndef MCC_MAP_VH
`define MCC_MAP_VH

// ----------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------
`define MCC_IDX_DUTY1     7'h30
`define MCC_IDX_DUTY2     7'h31
`define MCC_IDX_DUTY3     7'h32
`define MCC_IDX_CFG1      7'h40
`define MCC_IDX_STAT      7'h41
`define MCC_IDX_FAN1MIN   7'h55
`define MCC_IDX_PWMINV    7'h5C
`define MCC_IDX_CFG2      7'h73
`define MCC_IDX_CFG4      7'h7D
`define MCC_IDX_TEST2     7'h7F

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MCC_CFG2_AVG      4
`define MCC_CFG2_ATTENUATOR_BYPASS     5
`define MCC_CFG2_SINGLE_CHANNEL_A     6
`define MCC_CFG2_SHUTDOWN_REQUEST     7
`define MCC_CFG1_LOCK     1
`define MCC_TEST2_EXT     2
`define MCC_CHSEL_HI      7
`define MCC_CHSEL_LO      5

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define MCC_RST_BYTE      8'h00
`define MCC_SINGLE_CHANNEL_A_AVG_CYC  12'h400
`define MCC_SINGLE_CHANNEL_A_FAST_CYC 12'h040
`define MCC_LAST_CH       3'h7

`endif

// ### design/mcc_sync.v
/*
 * Two-stage synchroniser for a pin, with a registered rising-edge pulse.
 * Assumes the pin is asynchronous to clk_i.
 */
`timescale 1ns/10ps
module mcc_sync (
    input  wire clk_i,    // system clock
    input  wire rst_i,    // sync reset, high
    input  wire pin_i,    // asynchronous pin
    output wire level_o,  // synchronised level
    output reg  rise_o    // one-cycle rising-edge pulse
);
    reg meta;
    reg sync;
    reg prev;

    // only the second stage reads the first
    always @(posedge clk_i) begin
        if (rst_i) begin
            meta   <= 1'b0;
            sync   <= 1'b0;
            prev   <= 1'b0;
            rise_o <= 1'b0;
        end else begin
            meta   <= pin_i;
            sync   <= meta;
            prev   <= sync;
            rise_o <= sync & ~prev;
        end
    end

    assign level_o = sync;
endmodule

// ### design/mcc_seq.v
/*
 * Measurement sequencer: steps the converter through channels, or one
 * chosen channel, and latches its settings at the start of each cycle.
 * Assumes settings and the trigger edge are already in clk_i's domain.
 */
`timescale 1ns/10ps
`include "mcc_map.vh"
module mcc_seq (
    input  wire       clk_i,        // system clock
    input  wire       rst_i,        // sync reset, high
    input  wire       halt_i,       // shutdown: start no new cycle
    input  wire       avg_off_i,    // averaging off setting
    input  wire       single_i,     // single-channel setting
    input  wire       ext_en_i,     // external trigger enable
    input  wire       ext_edge_i,   // external trigger pulse
    input  wire [2:0] sel_i,        // single-channel selection
    input  wire [3:0] sense_i,      // sensing method setting
    output reg        start_o,      // conversion start pulse
    output reg  [2:0] chan_o,       // channel being converted
    output reg        avg_off_o,    // averaging off, latched
    output reg  [3:0] sense_o,      // sensing method, latched
    output reg        single_o,     // single mode, latched
    output wire       busy_o        // cycle in progress
);
    localparam S_IDLE = 4'b0001;
    localparam S_TRIG = 4'b0010;
    localparam S_SINGLE_CHANNEL_A = 4'b0100;
    localparam S_NEXT = 4'b1000;

    reg [3:0]  state;
    reg [11:0] cnt;
    reg        ext_l;

    always @(posedge clk_i) begin
        if (rst_i) begin
            state     <= S_IDLE;
            cnt       <= 12'h000;
            ext_l     <= 1'b0;
            start_o   <= 1'b0;
            chan_o    <= 3'h0;
            avg_off_o <= 1'b0;
            sense_o   <= 4'h0;
            single_o  <= 1'b0;
        end else begin
            start_o <= 1'b0;
            case (state)
            S_IDLE: begin
                if (!halt_i) begin
                    // settings move only at a cycle boundary
                    avg_off_o <= avg_off_i;
                    sense_o   <= sense_i;
                    single_o  <= single_i;
                    ext_l     <= single_i & ext_en_i;
                    chan_o    <= single_i ? sel_i : 3'h0;
                    state     <= S_TRIG;
                end
            end
            S_TRIG: begin
                if (!ext_l || ext_edge_i) begin
                    start_o <= 1'b1;
                    cnt     <= avg_off_o ? `MCC_SINGLE_CHANNEL_A_FAST_CYC
                                         : `MCC_SINGLE_CHANNEL_A_AVG_CYC;
                    state   <= S_SINGLE_CHANNEL_A;
                end else if (halt_i) begin
                    state <= S_IDLE;
                end
            end
            S_SINGLE_CHANNEL_A: begin
                if (cnt == 12'h001) begin
                    state <= S_NEXT;
                end else begin
                    cnt <= cnt - 12'h001;
                end
            end
            S_NEXT: begin
                // single mode repeats its one channel every cycle
                if (single_o || chan_o == `MCC_LAST_CH) begin
                    state <= S_IDLE;
                end else begin
                    chan_o <= chan_o + 3'h1;
                    state  <= S_TRIG;
                end
            end
            default: begin
                state <= S_IDLE;
            end
            endcase
        end
    end

    assign busy_o = (state != S_IDLE);
endmodule

// ### design/mcc_top.v
/*
 * Monitor configuration block: configuration register two and its
 * control effects, with a classic Wishbone register slave, plus the
 * few neighbouring registers whose fields it depends on: the lock,
 * the channel selection, the PWM invert bits, the 2-wire threshold
 * and the external trigger enable.
 *
 * Assumes a single clk_i domain; PWM generator and converter sit
 * outside and share clk_i; the fan-1 pin is asynchronous.
 * Assumes the bus master releases its request after ack and leaves
 * at least one idle cycle between accesses.
 * Assumes the converter takes adc_start_o as a one-cycle pulse and
 * reads adc_channel_o and adc_averaging_off_o with it.
 */
// Overview of operation
// - Each of the low four bits picks 2-wire sensing when set and 3-wire tach sensing when clear for its fan input.
// - The 2-wire sensing threshold comes from configuration register four, not from this register.
// - Setting bit 4 turns averaging off so each channel converts in the short time.
// - Setting bit 5 takes the attenuators off the four scaled voltage inputs.
// - Setting bit 6 makes the converter repeat one chosen input instead of scanning all channels.
// - The single channel is bits 7 to 5 of the fan-1 minimum high byte, codes 0 to 7 in the fixed channel order.
// - With test register two bit 2 set in single mode, each conversion waits for a rising edge on the fan-1 pin.
// - Setting bit 7 enters shutdown and drives every PWM output to its off level, low or high when inverted.
// - In shutdown the current duty-cycle registers read zero.
// - Once the lock bit of configuration register one is set, writes to this register are ignored.
// - After reset every bit of this register reads zero.
`timescale 1ns/10ps
`include "mcc_map.vh"
module mcc_top (
    input  wire        clk_i,                // 200 MHz system clock
    input  wire        rst_i,                // sync reset, high

    input  wire        wb_cyc_i,             // wishbone cycle
    input  wire        wb_stb_i,             // wishbone strobe
    input  wire        wb_we_i,              // wishbone write enable
    input  wire [9:0]  wb_adr_i,             // wishbone byte address
    input  wire [3:0]  wb_sel_i,             // wishbone byte selects
    input  wire [31:0] wb_dat_i,             // wishbone write data

    output reg  [31:0] wb_dat_o,             // wishbone read data
    output reg         wb_ack_o,             // wishbone acknowledge

    input  wire        fan1_speed_input_i,   // fan-1 pin, async
    input  wire [2:0]  pwm_raw_i,            // generator PWM, true level
    input  wire [23:0] pwm_duty_i,           // generator duty, 3 bytes

    output reg  [2:0]  pwm_o,                // PWM pins

    output wire [3:0]  two_wire_sense_o,     // per-fan 2-wire select
    output reg  [7:0]  two_wire_threshold_o, // 2-wire threshold code

    output reg         attenuator_bypass_o,  // attenuators removed
    output wire        adc_start_o,          // conversion start pulse
    output wire [2:0]  adc_channel_o,        // conversion channel
    output wire        adc_averaging_off_o,  // averaging off, latched
    output reg         shutdown_o            // shutdown active
);
    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    reg  [7:0] cfg1;
    reg  [7:0] cfg2;
    reg  [7:0] cfg4;
    reg  [7:0] fan1min;
    reg  [7:0] test2;
    reg  [7:0] pwminv;
    reg  [7:0] rd_byte;

    wire       lock          = cfg1[`MCC_CFG1_LOCK];

    wire       averaging_off = cfg2[`MCC_CFG2_AVG];
    wire       single_chan_a = cfg2[`MCC_CFG2_SINGLE_CHANNEL_A];
    wire       shutdown_req  = cfg2[`MCC_CFG2_SHUTDOWN_REQUEST];

    wire [2:0] pwm_polarity_invert = pwminv[2:0];
    wire [3:0] two_wire_sel  = cfg2[3:0];

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    function mcc_hit;
        input [9:0] adr;
        input [6:0] want;
        begin
            mcc_hit = (adr[9] == 1'b0) && (adr[8:2] == want);
        end
    endfunction

    // request stays high until ack; ~ack makes each access single
    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr  = req & wb_we_i & wb_sel_i[0];
    wire rd  = req & ~wb_we_i;

    // ----------------------------------------------------------------
    // bus slave: ack one cycle after the request
    // ----------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            // no wait states: ack follows the taking edge
            wb_ack_o <= req;

            if (rd) begin
                wb_dat_o <= {24'h00_0000, rd_byte};
            end
        end
    end

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            cfg1    <= `MCC_RST_BYTE;
            cfg2    <= `MCC_RST_BYTE;
            cfg4    <= `MCC_RST_BYTE;
            fan1min <= `MCC_RST_BYTE;
            test2   <= `MCC_RST_BYTE;
            pwminv  <= `MCC_RST_BYTE;
        end else if (wr) begin

            // lock is sticky: it also guards its own register
            if (mcc_hit(wb_adr_i, `MCC_IDX_CFG1) && !lock) begin
                cfg1 <= wb_dat_i[7:0];
            end

            if (mcc_hit(wb_adr_i, `MCC_IDX_CFG2) && !lock) begin
                cfg2 <= wb_dat_i[7:0];
            end

            if (mcc_hit(wb_adr_i, `MCC_IDX_CFG4)) begin
                cfg4 <= wb_dat_i[7:0];
            end

            if (mcc_hit(wb_adr_i, `MCC_IDX_FAN1MIN)) begin
                fan1min <= wb_dat_i[7:0];
            end

            if (mcc_hit(wb_adr_i, `MCC_IDX_TEST2)) begin
                test2 <= wb_dat_i[7:0];
            end

            if (mcc_hit(wb_adr_i, `MCC_IDX_PWMINV)) begin
                pwminv <= wb_dat_i[7:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // read mux; unmapped addresses read zero
    // ----------------------------------------------------------------
    wire       seq_busy;
    wire       seq_single;

    // the bytes are masked here, the generator itself keeps running
    function [7:0] mcc_duty;
        input       shut;
        input [7:0] duty;
        begin
            mcc_duty = shut ? 8'h00 : duty;
        end
    endfunction

    always @* begin
        rd_byte = 8'h00;
        if (wb_adr_i[9] == 1'b0) begin
            case (wb_adr_i[8:2])
            `MCC_IDX_DUTY1: begin
                rd_byte = mcc_duty(shutdown_req, pwm_duty_i[7:0]);
            end

            `MCC_IDX_DUTY2: begin
                rd_byte = mcc_duty(shutdown_req, pwm_duty_i[15:8]);
            end

            `MCC_IDX_DUTY3: begin
                rd_byte = mcc_duty(shutdown_req, pwm_duty_i[23:16]);
            end

            `MCC_IDX_CFG1: begin
                rd_byte = cfg1;
            end

            // live view, reading it has no side effect
            `MCC_IDX_STAT: begin
                rd_byte = {2'b00,
                           shutdown_req,
                           seq_single,
                           adc_channel_o,
                           seq_busy};
            end

            `MCC_IDX_FAN1MIN: begin
                rd_byte = fan1min;
            end

            `MCC_IDX_PWMINV: begin
                rd_byte = pwminv;
            end

            `MCC_IDX_CFG2: begin
                rd_byte = cfg2;
            end

            `MCC_IDX_CFG4: begin
                rd_byte = cfg4;
            end

            `MCC_IDX_TEST2: begin
                rd_byte = test2;
            end

            default: begin
                rd_byte = 8'h00;
            end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // direct control outputs
    // ----------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            attenuator_bypass_o  <= 1'b0;
            shutdown_o           <= 1'b0;
            two_wire_threshold_o <= 8'h00;
        end else begin
            // analog switch, no need to wait for a cycle boundary
            attenuator_bypass_o  <= cfg2[`MCC_CFG2_ATTENUATOR_BYPASS];

            shutdown_o           <= shutdown_req;
            two_wire_threshold_o <= cfg4;
        end
    end

    // ----------------------------------------------------------------
    // PWM pins: forced to the fan-off level in shutdown
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : pwm_pin
            always @(posedge clk_i) begin
                if (rst_i) begin
                    pwm_o[g] <= 1'b0;
                // off level is the invert bit itself
                end else if (shutdown_req) begin
                    pwm_o[g] <= pwm_polarity_invert[g];
                end else begin
                    pwm_o[g] <= pwm_raw_i[g] ^ pwm_polarity_invert[g];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // external conversion trigger on the fan-1 pin
    // ----------------------------------------------------------------
    wire ext_edge;

    mcc_sync i_mcc_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),

        .pin_i   (fan1_speed_input_i),
        .level_o (),
        .rise_o  (ext_edge)
    );

    // ----------------------------------------------------------------
    // measurement sequencer
    // ----------------------------------------------------------------
    mcc_seq i_mcc_seq (
        .clk_i      (clk_i),
        .rst_i      (rst_i),

        .halt_i     (shutdown_req),

        .avg_off_i  (averaging_off),
        .single_i   (single_chan_a),
        .ext_en_i   (test2[`MCC_TEST2_EXT]),
        .ext_edge_i (ext_edge),

        .sel_i      (fan1min[`MCC_CHSEL_HI:`MCC_CHSEL_LO]),
        .sense_i    (two_wire_sel),

        .start_o    (adc_start_o),
        .chan_o     (adc_channel_o),
        .avg_off_o  (adc_averaging_off_o),
        .sense_o    (two_wire_sense_o),
        .single_o   (seq_single),
        .busy_o     (seq_busy)
    );
endmodule

// ### verif/mcc_top_monitor.sv
/* assertion checker for mcc_top, bound to its ports
   assumes one clock domain and the synchronous high reset */
`timescale 1ns/10ps
`include "mcc_map.vh"
module mcc_monitor (
    input logic        clk_i,                // clock
    input logic        rst_i,                // reset
    input logic        wb_cyc_i,             // cycle
    input logic        wb_stb_i,             // strobe
    input logic        wb_we_i,              // write
    input logic [9:0]  wb_adr_i,             // address
    input logic [3:0]  wb_sel_i,             // selects
    input logic [31:0] wb_dat_i,             // write data
    input logic [31:0] wb_dat_o,             // read data
    input logic        wb_ack_o,             // ack
    input logic [2:0]  pwm_o,                // pwm pins
    input logic [3:0]  two_wire_sense_o,     // sensing
    input logic [7:0]  two_wire_threshold_o, // threshold
    input logic        attenuator_bypass_o,  // bypass
    input logic        adc_start_o,          // start
    input logic        adc_averaging_off_o,  // averaging off
    input logic        shutdown_o            // shutdown
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    wire [6:0] idx = wb_adr_i[8:2];
    wire wr0 = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i
               && wb_sel_i[0] && !wb_adr_i[9];
    wire wr_cfg2 = wr0 && idx == `MCC_IDX_CFG2;
    wire duty_rd = wb_ack_o && !wb_we_i && !wb_adr_i[9]
                   && idx >= `MCC_IDX_DUTY1 && idx <= `MCC_IDX_DUTY3;
    logic        lock;
    logic [11:0] gap;
    logic        prev_off;
    // lock only clears by reset, so a sticky copy is exact
    always @(posedge clk_i) begin
        if (rst_i) begin
            lock <= 1'b0;
            gap <= 12'hfff;
            prev_off <= 1'b0;
        end else begin
            if (wr0 && idx == `MCC_IDX_CFG1 && wb_dat_i[1])
                lock <= 1'b1;
            if (adc_start_o) begin
                gap <= 12'h001;
                prev_off <= adc_averaging_off_o;
            end else if (gap != 12'hfff)
                gap <= gap + 12'h001;
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_reset_zero;
        $past(rst_i) |-> !shutdown_o && !attenuator_bypass_o
            && two_wire_sense_o == 4'h0 && !adc_averaging_off_o;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("outputs not clear after reset");
    property p_bypass_cause;
        $changed(attenuator_bypass_o) |-> $past(wr_cfg2, 2);
    endproperty
    a_bypass_cause: assert property (p_bypass_cause)
        else $error("bypass changed without a write");
    property p_off_level;
        shutdown_o && $past(shutdown_o) && $past(shutdown_o, 2)
            && !$past(wb_cyc_i) && !$past(wb_cyc_i, 2) |-> $stable(pwm_o);
    endproperty
    a_off_level: assert property (p_off_level)
        else $error("pwm moved during shutdown");
    property p_duty_zero;
        duty_rd && shutdown_o |-> wb_dat_o == 32'h0000_0000;
    endproperty
    a_duty_zero: assert property (p_duty_zero)
        else $error("duty read nonzero in shutdown");
    property p_locked;
        lock && wr_cfg2 |-> ##2 $stable(shutdown_o)
            && $stable(attenuator_bypass_o);
    endproperty
    a_locked: assert property (p_locked)
        else $error("locked register changed");
    property p_thresh;
        wr0 && idx == `MCC_IDX_CFG4 |->
            ##2 two_wire_threshold_o == $past(wb_dat_i[7:0], 2);
    endproperty
    a_thresh: assert property (p_thresh)
        else $error("threshold not taken from its register");
    property p_avg_latch;
        $changed(adc_averaging_off_o) |-> ##[1:2] adc_start_o;
    endproperty
    a_avg_latch: assert property (p_avg_latch)
        else $error("averaging changed outside a cycle start");
    property p_gap;
        adc_start_o |-> gap >= (prev_off ? 12'h040 : 12'h400);
    endproperty
    a_gap: assert property (p_gap)
        else $error("conversion shorter than its length");
    c_shutdown_request: cover property ($rose(shutdown_o));
    c_lock: cover property (lock && wr_cfg2);
    c_fast: cover property (adc_start_o && adc_averaging_off_o);
endmodule
bind mcc_top mcc_monitor i_mcc_monitor (.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .pwm_o, .two_wire_sense_o, .two_wire_threshold_o,
    .attenuator_bypass_o, .adc_start_o, .adc_averaging_off_o,
    .shutdown_o);

// ### verif/mcc_top_tb.sv
/* self-checking bench for mcc_top: bus access, settings, sequencer,
   shutdown and lock; assumes the monitor is bound to the design */
`timescale 1ns/10ps
`include "mcc_map.vh"
module mcc_top_tb;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [9:0]  wb_adr_i = 10'h000;
    logic [3:0]  wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic        fan_pin = 1'b0;
    logic [2:0]  pwm_raw_i = 3'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [2:0]  pwm_o;
    logic [3:0]  two_wire_sense_o;
    logic [7:0]  two_wire_threshold_o;
    logic        attenuator_bypass_o;
    logic        adc_start_o;
    logic [2:0]  adc_channel_o;
    logic        adc_averaging_off_o;
    logic        shutdown_o;
    int          fails = 0;
    int          compares = 0;
    int          n;
    logic [31:0] q;
    mcc_top i_mcc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .fan1_speed_input_i(fan_pin),
        .pwm_raw_i(pwm_raw_i), .pwm_duty_i(24'h56_3412), .pwm_o(pwm_o),
        .two_wire_sense_o(two_wire_sense_o),
        .two_wire_threshold_o(two_wire_threshold_o),
        .attenuator_bypass_o(attenuator_bypass_o),
        .adc_start_o(adc_start_o), .adc_channel_o(adc_channel_o),
        .adc_averaging_off_o(adc_averaging_off_o),
        .shutdown_o(shutdown_o));
    // ------------------------------------------------------------
    // clock, stimulus helpers
    // ------------------------------------------------------------
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    // a moving raw level makes a stuck off level visible
    always @(posedge clk_i) pwm_raw_i <= pwm_raw_i + 3'h1;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [9:0] a,
                      input logic [7:0] d);
        int k;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= {24'h00_0000, d};
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 50);
        if (k >= 50) fails++;
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [6:0] i, input logic [7:0] d);
        wb(1'b1, {1'b0, i, 2'b00}, d);
    endtask
    task automatic rd(input logic [6:0] i, input logic [7:0] e);
        wb(1'b0, {1'b0, i, 2'b00}, 8'h00);
        chk(q, {24'h00_0000, e});
    endtask
    task automatic wait_start;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (adc_start_o !== 1'b1 && n < 20000);
        if (n >= 20000) fails++;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rd(`MCC_IDX_CFG2, 8'h00);
        chk({shutdown_o, attenuator_bypass_o, two_wire_sense_o}, 0);
        wait_start;
        wait_start;
        chk(n >= 1024 && n <= 1030, 1);
    endtask
    task automatic t_bits;
        for (int i = 0; i < 6; i++) begin
            wr(`MCC_IDX_CFG2, 8'h01 << i);
            rd(`MCC_IDX_CFG2, 8'h01 << i);
            chk(attenuator_bypass_o, i == 5);
        end
        wr(`MCC_IDX_CFG4, 8'ha5);
        rd(`MCC_IDX_CFG4, 8'ha5);
        chk(two_wire_threshold_o, 8'ha5);
        wr(`MCC_IDX_CFG2, 8'h1a);
        wait_start;
        for (int i = 0; i < 12 && adc_channel_o !== 3'h0; i++) wait_start;
        chk(two_wire_sense_o, 4'ha);
        chk(adc_averaging_off_o, 1'b1);
        wait_start;
        chk(n >= 64 && n <= 70, 1);
    endtask
    task automatic t_single;
        wr(`MCC_IDX_CFG2, 8'h50);
        for (int c = 0; c < 8; c++) begin
            wr(`MCC_IDX_FAN1MIN, c << 5);
            for (int j = 0; j < 12; j++) wait_start;
            chk(adc_channel_o, c);
            wait_start;
            chk(adc_channel_o, c);
        end
    endtask
    task automatic t_ext;
        int seen;
        wr(`MCC_IDX_TEST2, 8'h04);
        repeat (100) @(posedge clk_i);
        seen = 0;
        repeat (300) @(posedge clk_i) seen += adc_start_o;
        chk(seen, 0);
        fan_pin <= 1'b1;
        wait_start;
        chk(n <= 8, 1);
        fan_pin <= 1'b0;
        wr(`MCC_IDX_TEST2, 8'h00);
    endtask
    task automatic t_shutdown_request;
        wr(`MCC_IDX_PWMINV, 8'h05);
        wr(`MCC_IDX_CFG2, 8'h80);
        repeat (4) @(posedge clk_i);
        chk(pwm_o, 3'h5);
        @(posedge clk_i);
        chk(pwm_o, 3'h5);
        rd(`MCC_IDX_DUTY1, 8'h00);
        rd(`MCC_IDX_DUTY3, 8'h00);
        wb(1'b0, 10'h200, 8'h00);
        chk(q, 0);
        wr(`MCC_IDX_CFG2, 8'h00);
        rd(`MCC_IDX_DUTY2, 8'h34);
        wr(`MCC_IDX_PWMINV, 8'h00);
    endtask
    task automatic t_lock;
        wr(`MCC_IDX_CFG2, 8'h20);
        wb_sel_i <= 4'he;
        wr(`MCC_IDX_CFG2, 8'h80);
        wb_sel_i <= 4'hf;
        rd(`MCC_IDX_CFG2, 8'h20);
        wr(`MCC_IDX_CFG1, 8'h02);
        wr(`MCC_IDX_CFG2, 8'hff);
        rd(`MCC_IDX_CFG2, 8'h20);
        chk(shutdown_o, 1'b0);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`MCC_IDX_CFG2, 8'h00);
    endtask
    task summarize;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_bits;
        t_single;
        t_ext;
        t_shutdown_request;
        t_lock;
        summarize;
    end
    // the tests need about 15000 cycles
    initial begin
        repeat (40000) @(posedge clk_i);
        fails++;
        summarize;
    end
endmodule
